//--- dv/pbe_pci_peer.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far-side targets on both buses: open-drain error lines
// ---------------------------------------------------------------
module pbe_pci_peer (
   input  wire logic p_req,
   input  wire logic s_req,
   input  wire logic p_out,
   input  wire logic p_oe,
   input  wire logic s_out,
   input  wire logic s_oe,
   output logic      p_pin,
   output logic      s_pin
);
   // a released line floats up to its pull-up; any low driver wins
   assign p_pin = (p_req || (p_oe && !p_out)) ? 1'h0 : 1'h1;
   assign s_pin = (s_req || (s_oe && !s_out)) ? 1'h0 : 1'h1;
endmodule : pbe_pci_peer

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "pbe_regs.svh"
module tb_top;
   logic              aclk = 1'h0, aresetn = 1'h0;
   logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]       wdata = 32'h0, rdata;
   logic [1:0]        bresp, rresp;
   logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic              arvalid = 1'h0, rready = 1'h0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic              p_req = 1'h0, s_req = 1'h0, p_pin, s_pin;
   logic              p_out, p_oe, s_out, s_oe, e_out, e_oe, irq;
   logic [2:0]        en_v = 3'h0;
   logic [3:0]        wstrb = 4'hF;
   int                failures = 0, samples_checked = 0;
   int                p_cnt = 0, s_cnt = 0, e_cnt = 0;
   localparam logic [1:0] TG = 2'h1, MS = 2'h2, WIN = 2'h1, PE = 2'h2;
   localparam logic [1:0] RD = pbe_pkg::PBE_TXN_READ;
   localparam logic [1:0] PST = pbe_pkg::PBE_TXN_POSTED;
   localparam logic [1:0] DLY = pbe_pkg::PBE_TXN_DELAYED;
   localparam logic       DN = 1'h0, UP = 1'h1;
   localparam pbe_pkg::pbe_bus_s IDLE = '{1'h0, 1'h0,
      pbe_pkg::PBE_TXN_NONE, pbe_pkg::PBE_DIR_DOWN, 1'h0, 1'h0};
   pbe_pkg::pbe_bus_s pri_bus = IDLE, sec_bus = IDLE;

   always #12.5 aclk = ~aclk;

   pbe_bridge_parity DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pri_bus(pri_bus), .sec_bus(sec_bus),
      .primary_parity_err_n_in(p_pin), .primary_parity_err_n_out(p_out),
      .primary_parity_err_n_oe(p_oe), .secondary_parity_err_n_in(s_pin),
      .secondary_parity_err_n_out(s_out),
      .secondary_parity_err_n_oe(s_oe), .primary_system_err_n_out(e_out),
      .primary_system_err_n_oe(e_oe), .irq(irq));

   pbe_pci_peer PEER (
      .p_req(p_req), .s_req(s_req), .p_out(p_out), .p_oe(p_oe),
      .s_out(s_out), .s_oe(s_oe), .p_pin(p_pin), .s_pin(s_pin));

   // cycles each line is driven low
   always @(posedge aclk) begin
      if (p_oe === 1'h1 && p_out === 1'h0) p_cnt++;
      if (s_oe === 1'h1 && s_out === 1'h0) s_cnt++;
      if (e_oe === 1'h1 && e_out === 1'h0) e_cnt++;
   end

   function automatic pbe_pkg::pbe_bus_s mk(input logic [1:0] r, x,
                                            input logic d,
                                            input logic [1:0] f);
      mk = '{r[1], r[0], pbe_pkg::pbe_txn_e'(x), pbe_pkg::pbe_dir_e'(d),
             f[1], f[0]};
   endfunction : mk

   task automatic finish_test;
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] ex, got);
      samples_checked++;
      if (got !== ex) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'h1) awvalid <= 1'h0;
         if (wvalid && wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      bready <= 1'h0;
      if (n == 50) begin
         failures++;
         finish_test();
      end
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : axi_wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex,
                         input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      rready <= 1'h0;
      if (n == 50) begin
         failures++;
         finish_test();
      end
      chk("rdata", ex, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask : rd_chk

   // pin = {primary, secondary} pulled low by the far target two cycles
   // ahead, so the synchronised level is there when the window opens;
   // ex = {system, secondary, primary} expected low-pulse counts
   task automatic try_event(input logic [2:0] c,
                            input pbe_pkg::pbe_bus_s pb, sb,
                            input logic [1:0] pin, input logic [2:0] ex);
      axi_wr(`PBE_OFF_CTRL, {29'h0, c}, `PBE_RESP_OKAY);
      #1;
      p_cnt = 0;
      s_cnt = 0;
      e_cnt = 0;
      @(posedge aclk);
      p_req <= pin[1];
      s_req <= pin[0];
      repeat (2) @(posedge aclk);
      pri_bus <= pb;
      sec_bus <= sb;
      @(posedge aclk);
      pri_bus <= IDLE;
      sec_bus <= IDLE;
      p_req   <= 1'h0;
      s_req   <= 1'h0;
      repeat (5) @(posedge aclk);
      #1;
      chk("p_cnt", {31'h0, ex[0]}, p_cnt);
      chk("s_cnt", {31'h0, ex[1]}, s_cnt);
      chk("e_cnt", {31'h0, ex[2]}, e_cnt);
      chk("irq", {31'h0, |(ex & en_v)}, {31'h0, irq});
      rd_chk(`PBE_OFF_EVT_STAT, {29'h0, ex}, `PBE_RESP_OKAY);
      axi_wr(`PBE_OFF_EVT_CLR, 32'h7, `PBE_RESP_OKAY);
      @(posedge aclk);
      #1;
      chk("irq_clr", 32'h0, {31'h0, irq});
   endtask : try_event

   task automatic t_regs;
      rd_chk(`PBE_OFF_CTRL, 32'h0, `PBE_RESP_OKAY);
      rd_chk(`PBE_OFF_EVT_STAT, 32'h0, `PBE_RESP_OKAY);
      rd_chk(`PBE_OFF_EVT_EN, 32'h0, `PBE_RESP_OKAY);
      rd_chk(8'h40, 32'h0, `PBE_RESP_SLVERR);
      axi_wr(8'h40, 32'h7, `PBE_RESP_SLVERR);
      axi_wr(`PBE_OFF_EVT_STAT, 32'h7, `PBE_RESP_OKAY);
      rd_chk(`PBE_OFF_EVT_STAT, 32'h0, `PBE_RESP_OKAY);
      rd_chk(`PBE_OFF_EVT_CLR, 32'h0, `PBE_RESP_OKAY);
      axi_wr(`PBE_OFF_CTRL, 32'hFFFFFFFD, `PBE_RESP_OKAY);
      rd_chk(`PBE_OFF_CTRL, 32'h5, `PBE_RESP_OKAY);
      // a write with the low byte lane off must leave the enables alone
      wstrb <= 4'h0;
      axi_wr(`PBE_OFF_CTRL, 32'h0, `PBE_RESP_OKAY);
      wstrb <= 4'hF;
      rd_chk(`PBE_OFF_CTRL, 32'h5, `PBE_RESP_OKAY);
      // quiet lines: nothing driven, nothing seen low
      rd_chk(`PBE_OFF_LIVE, 32'h0, `PBE_RESP_OKAY);
   endtask : t_regs

   task automatic t_pri_own;
      try_event(3'h1, mk(TG, PST, DN, PE), IDLE, 2'h0, 3'h1);
      try_event(3'h1, mk(MS, RD, UP, PE), IDLE, 2'h0, 3'h1);
      try_event(3'h6, mk(TG, DLY, DN, PE), IDLE, 2'h0, 3'h0);
      try_event(3'h7, mk(TG, RD, DN, PE), IDLE, 2'h0, 3'h0);
      try_event(3'h7, mk(TG, PST, DN, PE), IDLE, 2'h0, 3'h1);
   endtask : t_pri_own

   task automatic t_sec_own;
      try_event(3'h4, IDLE, mk(TG, PST, UP, PE), 2'h0, 3'h2);
      try_event(3'h4, IDLE, mk(MS, RD, DN, PE), 2'h0, 3'h2);
      try_event(3'h3, IDLE, mk(TG, DLY, UP, PE), 2'h0, 3'h0);
      try_event(3'h7, IDLE, mk(TG, PST, UP, PE), 2'h0, 3'h2);
   endtask : t_sec_own

   task automatic t_reflect;
      try_event(3'h7, IDLE, mk(MS, DLY, DN, WIN), 2'h1, 3'h1);
      try_event(3'h3, IDLE, mk(MS, DLY, DN, WIN), 2'h1, 3'h0);
      try_event(3'h7, mk(MS, DLY, UP, WIN), IDLE, 2'h2, 3'h2);
      try_event(3'h6, mk(MS, DLY, UP, WIN), IDLE, 2'h2, 3'h0);
   endtask : t_reflect

   task automatic t_serr;
      try_event(3'h7, IDLE, mk(MS, PST, DN, WIN), 2'h1, 3'h4);
      try_event(3'h7, mk(MS, PST, UP, WIN), IDLE, 2'h2, 3'h4);
      try_event(3'h3, IDLE, mk(MS, PST, DN, WIN), 2'h1, 3'h0);
      try_event(3'h6, mk(MS, PST, UP, WIN), IDLE, 2'h2, 3'h0);
      try_event(3'h5, IDLE, mk(MS, PST, DN, WIN), 2'h1, 3'h0);
   endtask : t_serr

   task automatic t_irq;
      en_v = 3'h4;
      axi_wr(`PBE_OFF_EVT_EN, 32'h4, `PBE_RESP_OKAY);
      rd_chk(`PBE_OFF_EVT_EN, 32'h4, `PBE_RESP_OKAY);
      try_event(3'h7, IDLE, mk(MS, PST, DN, WIN), 2'h1, 3'h4);
      try_event(3'h1, mk(TG, PST, DN, PE), IDLE, 2'h0, 3'h1);
      en_v = 3'h3;
      axi_wr(`PBE_OFF_EVT_EN, 32'h3, `PBE_RESP_OKAY);
      try_event(3'h4, IDLE, mk(TG, PST, UP, PE), 2'h0, 3'h2);
   endtask : t_irq

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_pri_own();
      t_sec_own();
      t_reflect();
      t_serr();
      t_irq();
      finish_test();
   end
endmodule : tb_top

//--- hdl/pbe_bridge_parity.sv
// Functional notes
// - primary parity error on primary write-target/read-initiator
// - downstream delayed write: secondary error reflected primary
// - secondary parity error on secondary write-target/read-initiator
// - upstream delayed write: primary error reflected secondary
// - system error only for posted-write target-bus error
// - no system error when detected as posted target
// - system error needs both parity response enables
// - system error needs system error enable too
// - reads and delayed writes never raise system error
// - system error sets signaled system error status
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pbe_regs.svh"
module pbe_bridge_parity (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite slave
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // transaction context from the bridge core
   input  wire pbe_pkg::pbe_bus_s pri_bus,
   input  wire pbe_pkg::pbe_bus_s sec_bus,
   // pins
   input  wire logic              primary_parity_err_n_in,
   output logic                   primary_parity_err_n_out,
   output logic                   primary_parity_err_n_oe,
   input  wire logic              secondary_parity_err_n_in,
   output logic                   secondary_parity_err_n_out,
   output logic                   secondary_parity_err_n_oe,
   output logic                   primary_system_err_n_out,
   output logic                   primary_system_err_n_oe,
   output logic                   irq
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic pri_pin_q;
   logic sec_pin_q;

   pbe_sync2 u_sync_pri (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (primary_parity_err_n_in),
      .q       (pri_pin_q)
   );

   pbe_sync2 u_sync_sec (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (secondary_parity_err_n_in),
      .q       (sec_pin_q)
   );

   // ------------------------------------------------------------
   // error decisions
   // ------------------------------------------------------------
   pbe_pkg::pbe_main_s st;
   pbe_pkg::pbe_main_s next_st;

   logic pri_per;
   logic sec_per;
   logic serr_en;
   logic pri_seen;
   logic sec_seen;
   logic pri_role;
   logic sec_role;
   logic pri_go;
   logic sec_go;
   logic dwr_down;
   logic dwr_up;
   logic pw_up_hit;
   logic pw_down_hit;
   logic serr_go;

   assign pri_per  = st.ctrl[`PBE_CTRL_PRI_PER];
   assign sec_per  = st.ctrl[`PBE_CTRL_SEC_PER];
   assign serr_en  = st.ctrl[`PBE_CTRL_SERR_EN];
   // a low line is an error report
   assign pri_seen = !pri_pin_q;
   assign sec_seen = !sec_pin_q;

   // write target or read initiator on that bus
   assign pri_role = (pri_bus.target && (pri_bus.txn == pbe_pkg::PBE_TXN_POSTED
                   || pri_bus.txn == pbe_pkg::PBE_TXN_DELAYED))
                   || (pri_bus.master && pri_bus.txn == pbe_pkg::PBE_TXN_READ);
   assign sec_role = (sec_bus.target && (sec_bus.txn == pbe_pkg::PBE_TXN_POSTED
                   || sec_bus.txn == pbe_pkg::PBE_TXN_DELAYED))
                   || (sec_bus.master && sec_bus.txn == pbe_pkg::PBE_TXN_READ);

   // completion of a delayed write, as master on the target bus
   assign dwr_down = sec_bus.perr_win && sec_bus.master && sec_seen
                   && sec_bus.txn == pbe_pkg::PBE_TXN_DELAYED
                   && sec_bus.dir == pbe_pkg::PBE_DIR_DOWN;
   assign dwr_up   = pri_bus.perr_win && pri_bus.master && pri_seen
                   && pri_bus.txn == pbe_pkg::PBE_TXN_DELAYED
                   && pri_bus.dir == pbe_pkg::PBE_DIR_UP;

   assign pri_go = (pri_bus.par_err && pri_role && pri_per)
                 || (dwr_down && pri_per && sec_per);
   assign sec_go = (sec_bus.par_err && sec_role && sec_per)
                 || (dwr_up && pri_per && sec_per);

   // only the target's report on a posted write counts; our own
   // detection as target is answered with the parity line alone
   assign pw_up_hit   = pri_bus.perr_win && pri_bus.master && pri_seen
                      && pri_bus.txn == pbe_pkg::PBE_TXN_POSTED
                      && pri_bus.dir == pbe_pkg::PBE_DIR_UP;
   assign pw_down_hit = sec_bus.perr_win && sec_bus.master && sec_seen
                      && sec_bus.txn == pbe_pkg::PBE_TXN_POSTED
                      && sec_bus.dir == pbe_pkg::PBE_DIR_DOWN;
   assign serr_go = (pw_up_hit || pw_down_hit)
                  && pri_per && sec_per
                  && serr_en;

   pbe_perr_drv u_drv_pri (
      .aclk    (aclk),
      .aresetn (aresetn),
      .go      (pri_go),
      .pin_n   (primary_parity_err_n_out),
      .oe      (primary_parity_err_n_oe)
   );

   pbe_perr_drv u_drv_sec (
      .aclk    (aclk),
      .aresetn (aresetn),
      .go      (sec_go),
      .pin_n   (secondary_parity_err_n_out),
      .oe      (secondary_parity_err_n_oe)
   );

   // ------------------------------------------------------------
   // register file and bus slave
   // ------------------------------------------------------------
   logic       do_write;
   logic [2:0] evt;
   logic [2:0] clr;
   logic [7:0] rd_addr;

   assign s_axi_awready = !st.aw_got && !st.bvalid;
   assign s_axi_wready  = !st.w_got && !st.bvalid;
   assign s_axi_arready = !st.rvalid;
   assign do_write      = st.aw_got && st.w_got && !st.bvalid;
   assign rd_addr       = {s_axi_araddr[7:2], 2'h0};
   assign evt           = {serr_go, sec_go, pri_go};

   always_comb begin
      next_st = st;
      clr     = 3'h0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got  = 1'b1;
         next_st.aw_addr = {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got  = 1'b1;
         next_st.w_byte = s_axi_wdata[7:0];
         next_st.w_stb  = s_axi_wstrb[0];
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (do_write) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = `PBE_RESP_OKAY;
         case (st.aw_addr)
            `PBE_OFF_CTRL: begin
               if (st.w_stb) next_st.ctrl = st.w_byte[2:0];
            end
            `PBE_OFF_EVT_CLR: begin
               if (st.w_stb) clr = st.w_byte[2:0];
            end
            `PBE_OFF_EVT_EN: begin
               if (st.w_stb) next_st.en = st.w_byte[2:0];
            end
            `PBE_OFF_LIVE,
            `PBE_OFF_EVT_STAT: begin
               next_st.bresp = `PBE_RESP_OKAY;
            end
            default: begin
               next_st.bresp = `PBE_RESP_SLVERR;
            end
         endcase
      end
      // a new event outweighs a clear in the same cycle
      next_st.stat = (st.stat & ~clr) | evt;
      next_st.irq  = |(next_st.stat & next_st.en);
      // one clock low per reported posted-write error
      next_st.serr_n  = !serr_go;
      next_st.serr_oe = serr_go;
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = `PBE_RESP_OKAY;
         next_st.rdata  = 32'h0000_0000;
         case (rd_addr)
            `PBE_OFF_CTRL:     next_st.rdata[2:0] = st.ctrl;
            `PBE_OFF_LIVE: begin
               next_st.rdata[4:0] = {st.serr_oe,
                                     secondary_parity_err_n_oe,
                                     primary_parity_err_n_oe,
                                     sec_seen, pri_seen};
            end
            `PBE_OFF_EVT_STAT: next_st.rdata[2:0] = st.stat;
            `PBE_OFF_EVT_CLR:  next_st.rdata = 32'h0000_0000;
            `PBE_OFF_EVT_EN:   next_st.rdata[2:0] = st.en;
            default:           next_st.rresp = `PBE_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st         <= '0;
         st.ctrl    <= `PBE_CTRL_RST;
         st.stat    <= `PBE_EVT_RST;
         st.en      <= `PBE_EVT_RST;
         st.serr_n  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_bvalid             = st.bvalid;
   assign s_axi_bresp              = st.bresp;
   assign s_axi_rvalid             = st.rvalid;
   assign s_axi_rdata              = st.rdata;
   assign s_axi_rresp              = st.rresp;
   assign primary_system_err_n_out = st.serr_n;
   assign primary_system_err_n_oe  = st.serr_oe;
   assign irq                      = st.irq;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   pri_detect_a: assert property (
      pri_bus.par_err && pri_role && pri_per
      |=> primary_parity_err_n_oe && !primary_parity_err_n_out)
      else $error("primary parity error not reported");
   dwr_down_a: assert property (
      dwr_down && pri_per && sec_per |=> !primary_parity_err_n_out)
      else $error("downstream delayed write error not reflected");
   sec_detect_a: assert property (
      sec_bus.par_err && sec_role && sec_per
      |=> secondary_parity_err_n_oe && !secondary_parity_err_n_out)
      else $error("secondary parity error not reported");
   dwr_up_a: assert property (
      dwr_up && pri_per && sec_per |=> !secondary_parity_err_n_out)
      else $error("upstream delayed write error not reflected");
   serr_cause_a: assert property (
      primary_system_err_n_oe |-> $past(pw_up_hit || pw_down_hit))
      else $error("system error without posted write report");
   serr_self_a: assert property (
      pri_bus.target && pri_bus.par_err && !pw_down_hit
      && !(pri_bus.master && pri_bus.perr_win) |=> !primary_system_err_n_oe)
      else $error("system error for own target detection");
   serr_enables_a: assert property (
      !(pri_per && sec_per) |=> !primary_system_err_n_oe)
      else $error("system error with a parity response disabled");
   serr_enable_a: assert property (
      $rose(primary_system_err_n_oe) |-> $past(serr_en, 1))
      else $error("system error with its enable clear");
   serr_txn_a: assert property (
      pri_bus.txn != pbe_pkg::PBE_TXN_POSTED
      && sec_bus.txn != pbe_pkg::PBE_TXN_POSTED
      |=> !primary_system_err_n_oe)
      else $error("system error from read or delayed write");
   serr_level_a: assert property (
      primary_system_err_n_oe == !primary_system_err_n_out)
      else $error("system error line driven high");
   serr_status_a: assert property (
      primary_system_err_n_oe |-> st.stat[`PBE_EVT_SIG_SERR]
      ##1 (st.stat[`PBE_EVT_SIG_SERR] || $past(clr[`PBE_EVT_SIG_SERR])))
      else $error("signaled system error status not set");

   pri_perr_c: cover property (pri_go ##1 !primary_parity_err_n_out);
   sec_perr_c: cover property (dwr_up ##1 !secondary_parity_err_n_out);
   serr_up_c:  cover property (serr_go && pw_up_hit ##1 irq);
   serr_dn_c:  cover property (serr_go && pw_down_hit);
endmodule : pbe_bridge_parity

//--- hdl/pbe_perr_drv.sv
`timescale 1ns/1ps
module pbe_perr_drv (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic go,
   output logic      pin_n,
   output logic      oe
);
   pbe_pkg::pbe_drv_s st;
   pbe_pkg::pbe_drv_s next_st;

   // sustained tri-state: low while asserted, one cycle high, then float
   always_comb begin
      next_st = st;
      case (st.st)
         pbe_pkg::PBE_DRV_IDLE,
         pbe_pkg::PBE_DRV_HIGH: begin
            next_st.st = go ? pbe_pkg::PBE_DRV_LOW
                       : (st.st == pbe_pkg::PBE_DRV_HIGH)
                         ? pbe_pkg::PBE_DRV_IDLE : pbe_pkg::PBE_DRV_IDLE;
         end
         pbe_pkg::PBE_DRV_LOW: begin
            next_st.st = go ? pbe_pkg::PBE_DRV_LOW : pbe_pkg::PBE_DRV_HIGH;
         end
         default: begin
            next_st.st = pbe_pkg::PBE_DRV_IDLE;
         end
      endcase
      next_st.pin_n = (next_st.st != pbe_pkg::PBE_DRV_LOW);
      next_st.oe    = (next_st.st != pbe_pkg::PBE_DRV_IDLE);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '{st: pbe_pkg::PBE_DRV_IDLE, pin_n: 1'b1, oe: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign pin_n = st.pin_n;
   assign oe    = st.oe;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   drv_low_a: assert property (go |=> oe && !pin_n)
      else $error("parity error line not driven low after request");
   drv_float_a: assert property (!oe |-> pin_n)
      else $error("released parity error line shows low");
   drv_release_a: assert property ($fell(oe) |-> $past(pin_n))
      else $error("line released without driving it high first");
endmodule : pbe_perr_drv

//--- hdl/pbe_pkg.sv
package pbe_pkg;

   // ------------------------------------------------------------
   // transaction context from the bridge core
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PBE_TXN_READ    = 2'h0,
      PBE_TXN_POSTED  = 2'h1,
      PBE_TXN_DELAYED = 2'h2,
      PBE_TXN_NONE    = 2'h3
   } pbe_txn_e;

   typedef enum logic {
      PBE_DIR_DOWN = 1'h0,
      PBE_DIR_UP   = 1'h1
   } pbe_dir_e;

   typedef struct packed {
      logic     master;
      logic     target;
      pbe_txn_e txn;
      pbe_dir_e dir;
      logic     par_err;
      logic     perr_win;
   } pbe_bus_s;

   // ------------------------------------------------------------
   // module state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PBE_DRV_IDLE = 2'h0,
      PBE_DRV_LOW  = 2'h1,
      PBE_DRV_HIGH = 2'h2
   } pbe_drv_e;

   typedef struct packed {
      pbe_drv_e st;
      logic     pin_n;
      logic     oe;
   } pbe_drv_s;

   typedef struct packed {
      logic s1;
      logic s2;
   } pbe_sync_s;

   typedef struct packed {
      logic [2:0]  ctrl;
      logic [2:0]  stat;
      logic [2:0]  en;
      logic        irq;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [7:0]  w_byte;
      logic        w_stb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        serr_n;
      logic        serr_oe;
   } pbe_main_s;

endpackage : pbe_pkg

//--- hdl/pbe_regs.svh
`ifndef PBE_REGS_SVH
`define PBE_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PBE_OFF_CTRL      8'h00
`define PBE_OFF_LIVE      8'h04
`define PBE_OFF_EVT_STAT  8'h08
`define PBE_OFF_EVT_CLR   8'h0C
`define PBE_OFF_EVT_EN    8'h10

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PBE_CTRL_PRI_PER  0
`define PBE_CTRL_SERR_EN  1
`define PBE_CTRL_SEC_PER  2
`define PBE_EVT_PRI_PERR  0
`define PBE_EVT_SEC_PERR  1
`define PBE_EVT_SIG_SERR  2

// ---------------------------------------------------------------
// reset values and answers
// ---------------------------------------------------------------
`define PBE_CTRL_RST      3'h0
`define PBE_EVT_RST       3'h0
`define PBE_RESP_OKAY     2'h0
`define PBE_RESP_SLVERR   2'h2

`endif

//--- hdl/pbe_sync2.sv
`timescale 1ns/1ps
module pbe_sync2 (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic d,
   output logic      q
);
   pbe_pkg::pbe_sync_s st;
   pbe_pkg::pbe_sync_s next_st;

   // idle level of an active-low pin is high
   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '{s1: 1'b1, s2: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule : pbe_sync2
